// file: ssp_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps


`include "ssp_map.svh"

module ssp_top (
  input  wire logic        pclk,       // System clock, 20 MHz.
  input  wire logic        presetn,    // Asynchronous reset, active low.
  input  wire logic [11:0] paddr,      // APB byte address.
  input  wire logic        psel,       // APB select.
  input  wire logic        penable,    // APB enable.
  input  wire logic        pwrite,     // APB direction, high for write.
  input  wire logic [31:0] pwdata,     // APB write data.
  output logic      [31:0] prdata,     // APB read data.
  output logic             pready,     // APB ready.
  output logic             pslverr,    // APB error for unmapped address.
  input  wire logic        scl_in,     // Serial clock pin.
  input  wire logic        sin_in,     // Serial data input pin.
  output logic             sout_out,   // Serial data output pin value.
  output logic             sout_oe_n,  // Serial data output enable, active low.
  output logic             irq,        // Level interrupt, high while unmasked status set.
  output logic             xfer_irq_n  // Core interrupt request, falls on byte end.
);
  import ssp_pkg::*;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  function automatic ssp_sel_t decode_sel(input logic [11:0] addr);
    ssp_sel_t sel;
    sel = SSP_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[11:2])
        `SSP_IDX_IRQ_DISABLE: sel = SSP_SEL_DISABLE;
        `SSP_IDX_SHIFT_DATA:  sel = SSP_SEL_DATA;
        `SSP_IDX_IRQ_STATUS:  sel = SSP_SEL_STATUS;
        `SSP_IDX_IRQ_MASK:    sel = SSP_SEL_MASK;
        `SSP_IDX_CONTROL:     sel = SSP_SEL_CONTROL;
        `SSP_IDX_STATE:       sel = SSP_SEL_STATE;
        default:              sel = SSP_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_sel

  ssp_sel_t  sel;
  logic      setup_phase;
  logic      wr_access;
  logic      wr_data;
  logic      wr_disable;
  logic      wr_status;
  logic      wr_mask;
  logic      wr_control;

  assign sel         = decode_sel(paddr);
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;
  assign wr_data     = wr_access & (sel == SSP_SEL_DATA);
  assign wr_disable  = wr_access & (sel == SSP_SEL_DISABLE);
  assign wr_status   = wr_access & (sel == SSP_SEL_STATUS);
  assign wr_mask     = wr_access & (sel == SSP_SEL_MASK);
  assign wr_control  = wr_access & (sel == SSP_SEL_CONTROL);

  // Read data is captured in the setup cycle, so every access completes
  // with no wait state while prdata still comes from a flip-flop.
  assign pready = 1'b1;

  // ****************************************************************
  // Serial pins and shifter.
  // ****************************************************************
  ssp_shift_if sif ();

  logic scl_fall;
  logic sin_sync;

  ssp_pin_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .scl_in   (scl_in),
    .sin_in   (sin_in),
    .scl_fall (scl_fall),
    .sin_sync (sin_sync)
  );

  assign sif.fall      = scl_fall;
  assign sif.sin_bit   = sin_sync;
  assign sif.load      = wr_data;
  assign sif.load_data = pwdata[7:0];

  ssp_shifter u_shifter (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  // ****************************************************************
  // Interrupt arming.
  // ****************************************************************
  logic armed_reg;
  logic byte_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (wr_data) begin
      armed_reg <= 1'b1;
    end else if (wr_disable) begin
      armed_reg <= 1'b0;
    end
  end

  // The same event serves both directions: a byte has been shifted in
  // and, at the same moment, the previous byte has been shifted out.
  assign byte_done = sif.byte_event & armed_reg;

  // Request line idles high and falls on byte end; it rises again when
  // software re-arms or disarms, which gives a fresh edge every byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_irq_n <= 1'b1;
    end else if (byte_done) begin
      xfer_irq_n <= 1'b0;
    end else if (wr_data || wr_disable) begin
      xfer_irq_n <= 1'b1;
    end
  end

  // ****************************************************************
  // Status, mask and control registers.
  // ****************************************************************
  logic       status_reg;
  logic       mask_reg;
  ssp_byte_t  control_reg;
  logic       od_sel;

  // A new byte end outranks a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~(wr_status & pwdata[`SSP_IRQ_BYTE_DONE_BIT]))
                    | byte_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `SSP_MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= pwdata[`SSP_IRQ_BYTE_DONE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `SSP_CTRL_RESET;
    end else if (wr_control) begin
      control_reg <= pwdata[7:0];
    end
  end

  assign od_sel = control_reg[`SSP_CTRL_OD_SEL_BIT];
  assign irq    = status_reg & mask_reg;

  // ****************************************************************
  // Serial output pin.
  // ****************************************************************
  // Open drain: the pin is only ever pulled low, when bit 7 is zero.
  // Once selected the pin is owned by the shifter and cannot serve as a
  // plain open-drain port line.
  assign sout_out = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sout_oe_n <= 1'b1;
    end else begin
      sout_oe_n <= ~(od_sel & ~sif.shift_data[7]);
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  function automatic logic [31:0] read_mux(input ssp_sel_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (s)
      SSP_SEL_DISABLE: v[0]   = armed_reg;
      SSP_SEL_DATA:    v[7:0] = sif.shift_data;
      SSP_SEL_STATUS:  v[0]   = status_reg;
      SSP_SEL_MASK:    v[0]   = mask_reg;
      SSP_SEL_CONTROL: v[7:0] = control_reg;
      SSP_SEL_STATE: begin
        v[3:0]                   = sif.bit_count;
        v[`SSP_STATE_DONE_BIT]   = ~sif.count_done_output;
        v[`SSP_STATE_ARMED_BIT]  = armed_reg;
      end
      SSP_SEL_NONE:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux(sel);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= (sel == SSP_SEL_NONE);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  AST_ARM_ON_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data |=> armed_reg)
    else $error("Data write did not arm the interrupt.");

  AST_DISARM_ANY_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_disable && !wr_data) |=> !armed_reg && (xfer_irq_n || $past(byte_done)))
    else $error("Disable write did not disarm regardless of value.");

  AST_EIGHTH_EDGE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (armed_reg && scl_fall && sif.bit_count == 4'h7 && !wr_data && !wr_disable)
    |=> !xfer_irq_n && status_reg)
    else $error("Eighth edge did not raise the interrupt.");

  AST_IRQ_FALLS_ONLY_ON_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(xfer_irq_n) |-> $past(byte_done))
    else $error("Request line fell without a byte end.");

  AST_NO_IRQ_WHEN_DISARMED: assert property (@(posedge pclk) disable iff (!presetn)
    !armed_reg |=> !$fell(xfer_irq_n))
    else $error("Interrupt raised while disarmed.");

  AST_DONE_AFTER_EIGHT: assert property (@(posedge pclk) disable iff (!presetn)
    sif.count_done_output == (sif.bit_count < `SSP_BITS_PER_BYTE))
    else $error("Done output disagrees with the edge count.");

  AST_WRITE_REENABLES: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data |=> sif.count_done_output && sif.bit_count == 4'h0)
    else $error("Data write did not re-enable the shift clock.");

  AST_OD_FOLLOWS_MSB: assert property (@(posedge pclk) disable iff (!presetn)
    od_sel |=> sout_oe_n == $past(sif.shift_data[7]))
    else $error("Open-drain pin does not follow bit 7.");

  AST_LEVEL_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    byte_done && mask_reg && !wr_mask |=> irq)
    else $error("Masked-in byte end did not raise the level interrupt.");

  // The checks below cover flag and pin behaviour that the bench
  // reaches at only a few points of its run.
  AST_STATUS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (status_reg && !(wr_status && pwdata[`SSP_IRQ_BYTE_DONE_BIT])) |=> status_reg)
    else $error("Byte-end status cleared without a write of one.");

  AST_STATUS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[`SSP_IRQ_BYTE_DONE_BIT] && !byte_done) |=> !status_reg)
    else $error("Writing one did not clear the byte-end status.");

  AST_REQUEST_RELEASED: assert property (@(posedge pclk) disable iff (!presetn)
    ((wr_data || wr_disable) && !byte_done) |=> xfer_irq_n)
    else $error("Request line stayed low after a data or disable write.");

  AST_PIN_RELEASED: assert property (@(posedge pclk) disable iff (!presetn)
    !od_sel |=> sout_oe_n)
    else $error("Serial output pin driven while open drain is not selected.");

  AST_INPUT_INTO_BIT0: assert property (@(posedge pclk) disable iff (!presetn)
    (scl_fall && sif.count_done_output && !wr_data) |=> sif.shift_data[0] == $past(sin_sync))
    else $error("Serial input did not enter bit 0.");

endmodule : ssp_top

// file: ssp_map.svh
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define SSP_IDX_IRQ_DISABLE 10'h0DC
`define SSP_IDX_SHIFT_DATA  10'h0DD
`define SSP_IDX_IRQ_STATUS  10'h0E0
`define SSP_IDX_IRQ_MASK    10'h0E1
`define SSP_IDX_CONTROL     10'h0E2
`define SSP_IDX_STATE       10'h0E3

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SSP_IRQ_BYTE_DONE_BIT 0
`define SSP_CTRL_OD_SEL_BIT   0
`define SSP_STATE_DONE_BIT    4
`define SSP_STATE_ARMED_BIT   5
`define SSP_SHIFT_RESET       8'h00
`define SSP_MASK_RESET        1'b0
`define SSP_CTRL_RESET        8'h00

// ****************************************************************
// Counts.
// ****************************************************************
`define SSP_BITS_PER_BYTE 4'h8
`define SSP_LAST_BIT      4'h7

`endif

// file: ssp_pkg.sv
package ssp_pkg;

  typedef logic [7:0] ssp_byte_t;
  typedef logic [3:0] ssp_count_t;

  // One-hot register select decoded from the APB address.
  typedef enum logic [6:0] {
    SSP_SEL_NONE    = 7'h01,
    SSP_SEL_DISABLE = 7'h02,
    SSP_SEL_DATA    = 7'h04,
    SSP_SEL_STATUS  = 7'h08,
    SSP_SEL_MASK    = 7'h10,
    SSP_SEL_CONTROL = 7'h20,
    SSP_SEL_STATE   = 7'h40
  } ssp_sel_t;

endpackage : ssp_pkg

// file: ssp_shift_if.sv
`timescale 1ns/1ps

interface ssp_shift_if;
  logic                load;              // One-cycle processor write to the shift register.
  ssp_pkg::ssp_byte_t  load_data;         // Value written with load.
  logic                fall;              // One-cycle falling edge of the serial clock.
  logic                sin_bit;           // Synchronised serial input.
  ssp_pkg::ssp_byte_t  shift_data;        // Shift register contents.
  ssp_pkg::ssp_count_t bit_count;         // Edges applied since the last load or reset.
  logic                count_done_output; // High while clocking is enabled.
  logic                byte_event;        // One-cycle pulse on the eighth edge.

  modport ctrl (output load, load_data, fall, sin_bit,
                input  shift_data, bit_count, count_done_output, byte_event);
  modport core (input  load, load_data, fall, sin_bit,
                output shift_data, bit_count, count_done_output, byte_event);
endinterface : ssp_shift_if

// file: ssp_pin_sync.sv
`timescale 1ns/1ps

module ssp_pin_sync (
  input  wire logic pclk,     // System clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic scl_in,   // Serial clock pin.
  input  wire logic sin_in,   // Serial data input pin.
  output logic      scl_fall, // One-cycle pulse per falling edge.
  output logic      sin_sync  // Synchronised data input.
);
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sin_meta_reg;

  // Idle level of both lines is high, so reset to one to avoid a false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_meta_reg <= 1'b1;
      sin_sync     <= 1'b1;
    end else begin
      sin_meta_reg <= sin_in;
      sin_sync     <= sin_meta_reg;
    end
  end

  assign scl_fall = scl_prev_reg & ~scl_sync_reg;

endmodule : ssp_pin_sync

// file: ssp_shifter.sv
`timescale 1ns/1ps

`include "ssp_map.svh"

module ssp_shifter (
  input wire logic pclk,    // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  ssp_shift_if.core sif     // Link to the register side.
);
  import ssp_pkg::*;

  ssp_byte_t  shift_reg;
  ssp_count_t count_reg;
  logic       clk_gate;

  // Clocking stops once bit 3 of the counter rises, i.e. after eight edges.
  assign clk_gate               = ~count_reg[3];
  assign sif.count_done_output  = clk_gate;
  assign sif.shift_data         = shift_reg;
  assign sif.bit_count          = count_reg;

  // ****************************************************************
  // Shift register.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= `SSP_SHIFT_RESET;
    end else if (sif.load) begin
      shift_reg <= sif.load_data;
    end else if (sif.fall && clk_gate) begin
      shift_reg <= {shift_reg[6:0], sif.sin_bit};
    end
  end

  // ****************************************************************
  // Bit counter.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 4'h0;
    end else if (sif.load) begin
      count_reg <= 4'h0;
    end else if (sif.fall && clk_gate) begin
      count_reg <= count_reg + 4'h1;
    end
  end

  // A load in the same cycle resets the counter, so it cancels the event.
  assign sif.byte_event = sif.fall & clk_gate & (count_reg == `SSP_LAST_BIT)
                          & ~sif.load;

  AST_SHIFT_MSB_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (sif.fall && clk_gate && !sif.load) |=> shift_reg[7:1] == $past(shift_reg[6:0]))
    else $error("Shift register did not move toward the MSB.");

  AST_COUNT_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    (count_reg == `SSP_BITS_PER_BYTE && !sif.load) |=> $stable(count_reg) && $stable(shift_reg))
    else $error("Clocking continued after eight edges.");

  AST_LOAD_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    sif.load |=> count_reg == 4'h0 && shift_reg == $past(sif.load_data))
    else $error("Write did not reload register and clear counter.");

endmodule : ssp_shifter

// file: ssp_peer.sv
`timescale 1ns/1ps

// ****************************************************************
// Far-side serial party: makes the serial clock and data input.
// ****************************************************************
module ssp_peer (
  output logic      scl,  // Serial clock, idles high between frames.
  output logic      sdi,  // Data towards the device input pin.
  input  wire logic line  // Open-drain data line from the device.
);
  // The clock stands high outside frames so no stray edge is counted.
  initial begin
    scl = 1'b1;
    sdi = 1'b1;
  end

  // A long half period stretches the clock as slow software would.
  task automatic xfer(input logic [7:0] tx, input int nb, input int half,
                      output logic [7:0] rx);
    rx = 8'hFF;
    // Pins change by non-blocking assignment so the synchronisers never race them.
    for (int i = 7; i > 7 - nb; i--) begin
      sdi <= tx[i];
      #(half);
      rx  = {rx[6:0], line};
      scl <= 1'b0;
      #(half);
      scl <= 1'b1;
    end
    #(half);
    // Released line returns to its pull-up level.
    sdi <= 1'b1;
  endtask : xfer
endmodule : ssp_peer

// file: serial_shift_port_tb.sv
`timescale 1ns/1ps
`include "ssp_map.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

// ****************************************************************
// Bench for the serial shift port.
// ****************************************************************
module serial_shift_port_tb;
  import ssp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scl_in, sin_in, sout_out, sout_oe_n, irq, xfer_irq_n, line;
  ssp_byte_t   rx;
  int          n_mismatch, checks;

  // Open-drain output with a pull-up on the line.
  assign line = sout_oe_n ? 1'b1 : sout_out;

  ssp_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sin_in(sin_in),
    .sout_out(sout_out), .sout_oe_n(sout_oe_n), .irq(irq),
    .xfer_irq_n(xfer_irq_n));

  ssp_peer peer (.scl(scl_in), .sdi(sin_in), .line(line));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task conclude;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
    apb(idx, 1'b0, 32'h0);
    `CHK(rd, {24'h000000, e})
  endtask : rdchk

  task automatic link(input logic [7:0] tx, input int nb, input int half);
    peer.xfer(tx, nb, half, rx);
    repeat (8) @(posedge pclk);
  endtask : link

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; presetn = 1'b0; n_mismatch = 0; checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(xfer_irq_n, 1'b1)
    `CHK(sout_oe_n, 1'b1)
    rdchk(`SSP_IDX_SHIFT_DATA, `SSP_SHIFT_RESET);
    rdchk(`SSP_IDX_STATE, 8'h00);
    rdchk(`SSP_IDX_CONTROL, `SSP_CTRL_RESET);
    rdchk(10'h3F0, 8'h00);
    `CHK(err, 1'b1)
    apb(`SSP_IDX_CONTROL, 1'b1, 32'h1);
    apb(`SSP_IDX_IRQ_MASK, 1'b1, 32'h1);
    apb(`SSP_IDX_SHIFT_DATA, 1'b1, 32'hA5);
    rdchk(`SSP_IDX_STATE, 8'h20);
    rdchk(`SSP_IDX_IRQ_DISABLE, 8'h01);
    link(8'h3C, 8, 200);
    `CHK(rx, 8'hA5)
    `CHK(xfer_irq_n, 1'b0)
    `CHK(irq, 1'b1)
    rdchk(`SSP_IDX_STATE, 8'h38);
    rdchk(`SSP_IDX_SHIFT_DATA, 8'h3C);
    // Falls beyond the eighth must leave the byte frozen.
    link(8'hC3, 8, 200);
    `CHK(rx, 8'h00)
    rdchk(`SSP_IDX_SHIFT_DATA, 8'h3C);
    rdchk(`SSP_IDX_IRQ_STATUS, 8'h01);
    apb(`SSP_IDX_IRQ_STATUS, 1'b1, 32'h1);
    rdchk(`SSP_IDX_IRQ_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    // A write in mid-byte restarts the count and withholds the interrupt.
    apb(`SSP_IDX_SHIFT_DATA, 1'b1, 32'h0F);
    `CHK(xfer_irq_n, 1'b1)
    link(8'hA0, 4, 200);
    rdchk(`SSP_IDX_STATE, 8'h24);
    rdchk(`SSP_IDX_SHIFT_DATA, 8'hFA);
    `CHK(xfer_irq_n, 1'b1)
    apb(`SSP_IDX_SHIFT_DATA, 1'b1, 32'h00);
    rdchk(`SSP_IDX_STATE, 8'h20);
    // Eight falls since arming, but the write restarted the count at four.
    link(8'h0F, 4, 200);
    `CHK(xfer_irq_n, 1'b1)
    apb(`SSP_IDX_IRQ_DISABLE, 1'b1, 32'h5A);
    rdchk(`SSP_IDX_STATE, 8'h04);
    apb(`SSP_IDX_IRQ_MASK, 1'b1, 32'h0);
    apb(`SSP_IDX_CONTROL, 1'b1, 32'h0);
    // The pin flop takes one more edge to follow the control write.
    @(posedge pclk);
    `CHK(sout_oe_n, 1'b1)
    link(8'h96, 8, 1000);
    `CHK(rx, 8'hFF)
    `CHK(xfer_irq_n, 1'b1)
    `CHK(irq, 1'b0)
    // Four falls were already counted, so only the first half of the byte enters.
    rdchk(`SSP_IDX_SHIFT_DATA, 8'h09);
    rdchk(`SSP_IDX_STATE, 8'h18);
    conclude();
  end
endmodule : serial_shift_port_tb
